// ### rtl/prsq_mem_seq.sv
// Memory-side power-up and hardware reset sequencer.
// Assumes pins synchronous to mclk; rst_b models power-on.
`timescale 1ns/10ps
`default_nettype none
module prsq_mem_seq
  import prsq_pkg::*;
#(
  parameter int unsigned WAIT_CYC = POWER_UP_WAIT_CYC
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link
  prsq_link_if.mem link,
  // User side
  input wire logic cfg_wr,
  input wire logic cfg_sel,
  input wire logic [15:0] cfg_wdata,
  input wire logic refresh_tick,
  output logic ready,
  output logic accept_select,
  output logic standby,
  output logic refresh_en,
  output logic data_valid,
  output logic hybrid_sleep,
  output logic deep_pd,
  output logic [15:0] cfg0_q,
  output logic [15:0] cfg1_q,
  output logic [ROW_W-1:0] row_q
);
  prsq_dev_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic hold;
  logic cfg_ok;

  assign hold = !link.mem_rst_n;
  assign cfg_ok = ready && cfg_wr && !link.cs_n;

  // The count only runs while reset is released, so a held reset delays it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PRSQ_RESET;
      cnt_q <= '0;
    end else if (hold) begin
      state_q <= PRSQ_RESET;
      cnt_q <= '0;
    end else begin
      case (state_q)
        PRSQ_RESET: begin
          state_q <= PRSQ_INIT;
          cnt_q <= '0;
        end
        PRSQ_INIT: begin
          if (cnt_q >= CNT_W'(WAIT_CYC - 1)) begin
            state_q <= PRSQ_READY;
          end
          cnt_q <= cnt_q + 1'b1;
        end
        PRSQ_READY: cnt_q <= '0;
        default: state_q <= PRSQ_RESET;
      endcase
    end
  end

  assign ready = (state_q == PRSQ_READY);
  // Select activity before the wait ends is ignored.
  assign accept_select = ready && !link.cs_n;
  assign standby = ready && link.cs_n && !hybrid_sleep && !deep_pd;

  // Configuration registers return to defaults on any reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg0_q <= CFG0_DEFAULT;
      cfg1_q <= CFG1_DEFAULT;
    end else if (hold) begin
      cfg0_q <= CFG0_DEFAULT;
      cfg1_q <= CFG1_DEFAULT;
    end else begin
      if (cfg_ok && !cfg_sel) begin
        cfg0_q <= cfg_wdata;
      end else if (cfg_ok && cfg_sel) begin
        cfg1_q <= cfg_wdata;
      end else if (ready && !link.cs_n) begin
        // Select low wakes from sleep and deep power-down.
        cfg1_q[SLEEP_REQ_BIT] <= 1'b0;
        cfg0_q[DPD_N_BIT] <= 1'b1;
      end
    end
  end

  assign hybrid_sleep = cfg1_q[SLEEP_REQ_BIT];
  assign deep_pd = !cfg0_q[DPD_N_BIT];

  // Refresh halts in reset and restarts from the default row.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      row_q <= ROW_DEFAULT;
    end else if (hold) begin
      row_q <= ROW_DEFAULT;
    end else if (refresh_en && refresh_tick) begin
      row_q <= row_q + 1'b1;
    end
  end

  assign refresh_en = !hold && !deep_pd && state_q != PRSQ_RESET;

  // Array contents stay invalid after reset until written again.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_valid <= 1'b0;
    end else if (hold || deep_pd) begin
      data_valid <= 1'b0;
    end else if (cfg_ok) begin
      data_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/prsq_pkg.sv
// Constants shared by the memory-side reset sequencer and the host-side sequencer.
// Assumes a single 20 MHz clock, mclk, on both ends.
// Contract
// - Device finishes self-init within 150 us.
// - Host keeps select high through power-up wait.
// - Wait count starts only after reset releases.
// - Host issues no transaction before wait ends.
// - No transaction in reset; 400 ns before select.
// - Reset low 200 ns; select 200 ns after.
// - Reset returns device to standby.
// - Reset restores configuration defaults.
// - Reset low stops refresh, data invalid.
// - Reset exits hybrid sleep and deep power-down.
// - Refresh resumes from default row counter.
// - Host treats array data lost after reset.
// - Reset clears sleep request bit.
package prsq_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned POWER_UP_WAIT_TIME_US = 150;
  localparam int unsigned RESET_PULSE_WIDTH_NS = 200;
  localparam int unsigned RESET_RELEASE_TO_SELECT_NS = 200;
  localparam int unsigned RESET_ASSERT_TO_SELECT_NS = 400;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Longest time rounds down; least times round up.
  localparam int unsigned POWER_UP_WAIT_CYC = POWER_UP_WAIT_TIME_US * CLK_MHZ;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_SEL_CYC = (RESET_RELEASE_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ASSERT_SEL_CYC = (RESET_ASSERT_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int ROW_W = 13;
  localparam logic [ROW_W-1:0] ROW_DEFAULT = 13'h0000;
  localparam logic [15:0] CFG0_DEFAULT = 16'h8f1f;
  localparam logic [15:0] CFG1_DEFAULT = 16'h0001;
  localparam int SLEEP_REQ_BIT = 5;
  localparam int DPD_N_BIT = 15;
  typedef enum logic [1:0] {
    PRSQ_RESET = 2'b00,
    PRSQ_INIT = 2'b01,
    PRSQ_READY = 2'b11
  } prsq_dev_state_type;
  typedef enum logic [2:0] {
    PRSQ_H_PWR = 3'b000,
    PRSQ_H_PULSE = 3'b001,
    PRSQ_H_RELEASE = 3'b011,
    PRSQ_H_WAIT = 3'b010,
    PRSQ_H_READY = 3'b110
  } prsq_host_state_type;
endpackage

// ### rtl/prsq_link_if.sv
// Link between host controller and memory: chip select and reset pins.
// Assumes both ends share mclk.
`timescale 1ns/10ps
`default_nettype none
interface prsq_link_if;
  logic cs_n;
  logic mem_rst_n;
  modport host (output cs_n, output mem_rst_n);
  modport mem (input cs_n, input mem_rst_n);
endinterface
`default_nettype wire

// ### rtl/prsq_host_seq.sv
// Host-side sequencer: drives memory reset and chip select with the required waits.
// Assumes the memory shares mclk.
`timescale 1ns/10ps
`default_nettype none
module prsq_host_seq
  import prsq_pkg::*;
#(
  parameter int unsigned WAIT_CYC = POWER_UP_WAIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // User side
  input wire logic reset_req,
  input wire logic xfer_req,
  output logic xfer_ok,
  output logic reload_needed,
  // Link
  prsq_link_if.host link
);
  prsq_host_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic rst_drv_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PRSQ_H_PWR;
      cnt_q <= '0;
    end else begin
      case (state_q)
        PRSQ_H_PWR: begin
          // Hold select high through power-up wait.
          // The count starts only once the memory reset pin is released, as the memory's own count does.
          if (rst_drv_q) begin
            cnt_q <= cnt_q + 1'b1;
          end
          if (cnt_q >= CNT_W'(WAIT_CYC)) begin
            state_q <= PRSQ_H_READY;
            cnt_q <= '0;
          end
        end
        PRSQ_H_PULSE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(RESET_PULSE_CYC - 1) && !reset_req) begin
            state_q <= PRSQ_H_RELEASE;
            cnt_q <= '0;
          end
        end
        PRSQ_H_RELEASE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(RELEASE_SEL_CYC)) begin
            state_q <= PRSQ_H_WAIT;
            cnt_q <= '0;
          end
        end
        PRSQ_H_WAIT: begin
          // The memory reinitialises after a reset release too.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(WAIT_CYC)) begin
            state_q <= PRSQ_H_READY;
          end
        end
        PRSQ_H_READY: begin
          cnt_q <= '0;
          if (reset_req) begin
            state_q <= PRSQ_H_PULSE;
          end
        end
        default: state_q <= PRSQ_H_PWR;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_drv_q <= 1'b0;
    end else begin
      rst_drv_q <= !(state_q == PRSQ_H_PULSE);
    end
  end

  // Data after a reset must be reloaded by the user.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reload_needed <= 1'b1;
    end else if (state_q == PRSQ_H_PULSE) begin
      reload_needed <= 1'b1;
    end else if (xfer_ok) begin
      reload_needed <= 1'b0;
    end
  end

  assign xfer_ok = (state_q == PRSQ_H_READY) && xfer_req && !reset_req;
  assign link.cs_n = !xfer_ok;
  assign link.mem_rst_n = rst_drv_q && (state_q != PRSQ_H_PULSE);
endmodule
`default_nettype wire

// ### sim/prsq_link_chk.sv
// Checker for the reset and select pins between host and memory.
// Assumes one clock; tb places it beside the link.
`timescale 1ns/10ps
`default_nettype none
module prsq_link_chk
  import prsq_pkg::*;
#(
  parameter int unsigned WAIT_CYC = POWER_UP_WAIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link
  input wire logic cs_n,
  input wire logic mem_rst_n
);
  logic [15:0] up_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Saturates so a long idle spell cannot wrap into a false early select.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      up_q <= 16'h0000;
    end else if (!mem_rst_n) begin
      up_q <= 16'h0000;
    end else if (up_q != 16'hffff) begin
      up_q <= up_q + 16'h0001;
    end
  end
  a_pulse_min_width: assert property ($fell(mem_rst_n) |-> !mem_rst_n[*4])
    else $error("reset pulse too short");
  a_release_to_select: assert property ($rose(mem_rst_n) |-> cs_n[*4])
    else $error("select too soon after reset release");
  a_assert_to_select: assert property ($fell(mem_rst_n) |-> cs_n[*8])
    else $error("select too soon after reset assert");
  a_select_in_reset: assert property (!mem_rst_n |-> cs_n)
    else $error("select during reset");
  a_wait_before_select: assert property (!cs_n |-> up_q > WAIT_CYC)
    else $error("select before wait period");
  a_release_select_hold: assert property ($rose(mem_rst_n) |-> cs_n[*8])
    else $error("select soon after reset release");
endmodule
`default_nettype wire

// ### sim/tb.sv
// Bench: host and memory sequencers joined by the link, held against a cycle model.
// Assumes the package, link and both sequencers compile first.
`timescale 1ns/10ps
`default_nettype none
module tb
  import prsq_pkg::*;
;
  localparam int unsigned WC = 20;
  logic mclk = 1'b0, rst_b = 1'b0, reset_req = 1'b0, xfer_req = 1'b0, cfg_wr = 1'b0, cfg_sel = 1'b0;
  logic refresh_tick = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic xfer_ok, reload_needed, ready, accept_select, standby, refresh_en, data_valid, hybrid_sleep, deep_pd;
  logic [15:0] cfg0_q, cfg1_q;
  logic [ROW_W-1:0] row_q;
  int miscompares = 0, compares = 0, seed = 36961, n, ticks;
  always #25 mclk = ~mclk;
  prsq_link_if link ();
  prsq_host_seq #(.WAIT_CYC(WC)) prsq_host_seq_i (.mclk(mclk), .rst_b(rst_b), .reset_req(reset_req),
    .xfer_req(xfer_req), .xfer_ok(xfer_ok), .reload_needed(reload_needed), .link(link.host));
  prsq_mem_seq #(.WAIT_CYC(WC)) prsq_mem_seq_i (.mclk(mclk), .rst_b(rst_b), .link(link.mem),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .refresh_tick(refresh_tick), .ready(ready),
    .accept_select(accept_select), .standby(standby), .refresh_en(refresh_en), .data_valid(data_valid),
    .hybrid_sleep(hybrid_sleep), .deep_pd(deep_pd), .cfg0_q(cfg0_q), .cfg1_q(cfg1_q), .row_q(row_q));
  prsq_link_chk #(.WAIT_CYC(WC)) prsq_link_chk_i (.mclk(mclk), .rst_b(rst_b), .cs_n(link.cs_n),
    .mem_rst_n(link.mem_rst_n));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The model counts cycles from reset release to ready; nothing else may shorten it.
  task automatic wait_up();
    n = 0;
    while (link.mem_rst_n !== 1'b1 && n < 400) begin
      @(negedge mclk);
      chk("ready in reset", 16'h0000, ready);
      chk("grant early", 16'h0000, xfer_ok);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      test_done();
    end
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      if (n == 0) chk("accept early", 16'h0000, accept_select);
      @(negedge mclk);
      n++;
    end
    chk("wait cycles", WC + 1, n);
    chk("refresh row", ROW_DEFAULT, row_q);
    chk("reload", 16'h0001, reload_needed);
    if (n >= 400) test_done();
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    xfer_req = 1'b1;
    wait_up();
    // Move the refresh row off its default so that the reset below has something to undo.
    ticks = 1 + ($unsigned($random(seed)) % 7);
    refresh_tick = 1'b1;
    repeat (ticks) @(negedge mclk);
    refresh_tick = 1'b0;
    chk("row advance", 16'(ROW_DEFAULT + ticks), row_q);
    for (int i = 0; i < 2; i++) begin
      @(negedge mclk);
      cfg_sel = i[0];
      cfg_wdata = 16'($random(seed));
      cfg_wdata[SLEEP_REQ_BIT] = 1'b1;
      cfg_wdata[DPD_N_BIT] = 1'b0;
      cfg_wr = 1'b1;
      xfer_req = 1'b1;
      // After a reset pulse the host grants a few cycles after the memory is ready, so the write is held until granted.
      n = 0;
      while (xfer_ok !== 1'b1 && n < 400) begin
        @(negedge mclk);
        n++;
      end
      if (n >= 400) begin
        miscompares++;
        test_done();
      end
      @(negedge mclk);
      cfg_wr = 1'b0;
      xfer_req = 1'b0;
      chk("low power entry", 16'h0001, i ? hybrid_sleep : deep_pd);
      chk("reload done", 16'h0000, reload_needed);
      reset_req = 1'b1;
      @(negedge mclk);
      reset_req = 1'b0;
      repeat (2) @(negedge mclk);
      chk("cfg0", CFG0_DEFAULT, cfg0_q);
      chk("cfg1", CFG1_DEFAULT, cfg1_q);
      chk("row in reset", 16'(ROW_DEFAULT), row_q);
      chk("refresh", 16'h0000, refresh_en);
      chk("valid", 16'h0000, data_valid);
      chk("sleep exit", 16'h0000, hybrid_sleep);
      chk("power down exit", 16'h0000, deep_pd);
      wait_up();
      chk("standby", 16'h0001, standby);
      chk("refresh resumed", 16'h0001, refresh_en);
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule
`default_nettype wire
